/* hw/kvs_pkg.sv */
// constants and types shared by the keyboard velocity scanner
package kvs_pkg;
  // matrix geometry
  localparam int ROWS_MAN = 8;
  localparam int KEYS_ROW = 8;
  localparam int CONTACTS = 16;
  localparam int PED_SEL = 4;
  localparam int PED_RET = 8;
  localparam int JUMPERS = 8;
  localparam int SLOTS = 13;
  localparam int MEM_DEPTH = 64;
  localparam int MEM_W = 9;
  localparam logic [3:0] ROW_LAST_MAN = 4'h7;
  localparam logic [3:0] ROW_JUMPER = 4'hc;
  localparam logic [2:0] KEY_LAST = 3'h7;
  localparam logic [5:0] KEY_COUNT = 6'h3d;
  localparam logic [4:0] PEDAL_LOW = 5'h02;
  localparam logic [12:0] DRV_IDLE = 13'h1fff;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int SETTLE_NS = 200;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC = 2;
  localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC + SYNC_CYC - 1);
  localparam int POLL_BASE_US = 250;
  localparam int POLL_BASE_CYC = POLL_BASE_US * CLK_MHZ;
  // byte layout
  localparam int KB_IRQ = 7;
  localparam int KB_ON = 6;
  localparam int VB_PEDAL = 7;
  localparam logic [6:0] VEL_MAX = 7'h7f;
  // port decode
  localparam logic ADDR_KEY = 1'b0;
  localparam logic ADDR_VEL = 1'b1;
  localparam int MASK_BIT = 0;
  localparam logic MASK_RST = 1'b0;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    KS_IDLE = 2'b00,
    KS_TIMING = 2'b01,
    KS_ON = 2'b10
  } kvs_key_t;

  typedef enum logic [2:0] {
    SC_INIT = 3'b000,
    SC_WAIT = 3'b001,
    SC_SETTLE = 3'b010,
    SC_RD = 3'b011,
    SC_UPD = 3'b100
  } kvs_scan_t;
endpackage

/* hw/kvs_key_mem.sv */
// per-key state memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module kvs_key_mem (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [5:0] waddr_i,
  input wire logic [kvs_pkg::MEM_W-1:0] wdata_i,
  input wire logic [5:0] raddr_i,
  output logic [kvs_pkg::MEM_W-1:0] rdata_o
);
  import kvs_pkg::*;
  logic [MEM_W-1:0] mem_r [MEM_DEPTH];

  // no reset here: the scanner clears every entry before its first poll
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem_r[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule
`default_nettype wire

/* hw/kvs_scanner.sv */
// keyboard velocity scanner: matrix scan, velocity timing, two-byte port
`timescale 1ns/10ps
`default_nettype none
module kvs_scanner #(
  parameter int unsigned POLL_BASE_CYCLES = kvs_pkg::POLL_BASE_CYC
) (
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  // master port
  input wire logic BUS_CS_I,
  input wire logic BUS_ADDR_I,
  input wire logic BUS_RD_I,
  input wire logic BUS_WR_I,
  input wire logic [7:0] BUS_WDATA_I,
  output logic [7:0] BUS_RDATA_O,
  output logic FAST_INTERRUPT_REQUEST_N_O,
  // key matrix
  output logic [kvs_pkg::ROWS_MAN-1:0] MATRIX_ADDR_N_O,
  input wire logic [kvs_pkg::CONTACTS-1:0] CONTACT_I,
  // pedal matrix and jumpers
  output logic [kvs_pkg::PED_SEL-1:0] PEDAL_SEL_N_O,
  output logic JUMPER_SEL_N_O,
  input wire logic [kvs_pkg::PED_RET-1:0] PEDAL_RETURN_LINE_I,
  output logic [kvs_pkg::JUMPERS-1:0] OPTION_JUMPERS_O,
  // rate coding switch
  input wire logic [1:0] RATE_SEL_I
);
  import kvs_pkg::*;

  kvs_scan_t st_r, st_nxt;
  logic [3:0] row_r, row_nxt;
  logic [2:0] key_r;
  logic [5:0] init_r;
  logic [7:0] settle_r;
  logic [31:0] tmr_r;
  logic tick_pend_r;
  logic [CONTACTS-1:0] con_s1_r, con_s2_r;
  logic [PED_RET-1:0] ret_s1_r, ret_s2_r;
  logic [1:0] rate_s1_r, rate_s2_r, rate_r;
  logic rate_taken_r;
  logic [SLOTS-1:0] drv_n_r;
  logic [31:0] pedal_r;
  logic irq_r, mask_r;
  logic [6:0] ev_key_r;
  logic [7:0] vel_r;
  logic [MEM_W-1:0] mem_rdata;

  // decode
  wire logic rd_key = CE_I && BUS_CS_I && BUS_RD_I && BUS_ADDR_I == ADDR_KEY;
  wire logic rd_vel = CE_I && BUS_CS_I && BUS_RD_I && BUS_ADDR_I == ADDR_VEL;
  wire logic wr_mask = CE_I && BUS_CS_I && BUS_WR_I && BUS_ADDR_I == ADDR_KEY;
  wire logic [31:0] period_w = 32'(POLL_BASE_CYCLES) << rate_r;
  wire logic tick = tmr_r == 32'h0;
  wire logic is_pedal = row_r > ROW_LAST_MAN;
  wire logic row_done = st_r == SC_UPD && key_r == KEY_LAST;
  wire logic init_we = st_r == SC_INIT;
  wire logic [5:0] man_pitch = {row_r[2:0], key_r};
  wire logic [4:0] ped_idx = {row_r[1:0], key_r};
  // contacts and returns read low when closed
  wire logic rest_open = con_s2_r[{key_r, 1'b0}];
  wire logic work_closed = !con_s2_r[{key_r, 1'b1}];
  wire logic ped_down = !ret_s2_r[key_r];
  wire kvs_key_t ks = kvs_key_t'(mem_rdata[MEM_W-1:MEM_W-2]);
  wire logic [6:0] cnt = mem_rdata[6:0];

  // per-key update
  kvs_key_t ks_nxt;
  logic [6:0] cnt_nxt;
  logic man_ev, man_on;
  always_comb begin
    ks_nxt = ks;
    cnt_nxt = cnt;
    man_ev = 1'b0;
    man_on = 1'b0;
    case (ks)
      KS_IDLE: begin
        if (rest_open) begin
          ks_nxt = KS_TIMING;
          cnt_nxt = 7'h00;
        end
      end
      KS_TIMING: begin
        if (work_closed) begin
          ks_nxt = KS_ON;
          man_ev = 1'b1;
          man_on = 1'b1;
        end else if (!rest_open) begin
          ks_nxt = KS_IDLE;
        end else if (cnt != VEL_MAX) begin
          cnt_nxt = cnt + 7'h01;
        end
      end
      KS_ON: begin
        if (!work_closed && !rest_open) begin
          ks_nxt = KS_IDLE;
          man_ev = 1'b1;
        end
      end
      default: begin
        ks_nxt = KS_IDLE;
      end
    endcase
  end

  // only 61 of the 64 matrix positions carry a key
  wire logic man_valid = man_pitch < KEY_COUNT;
  wire logic ped_valid = ped_idx >= PEDAL_LOW;
  wire logic ped_ev = ped_valid && ped_down != pedal_r[ped_idx];
  wire logic ev_set = st_r == SC_UPD && (is_pedal ? ped_ev : man_ev && man_valid);
  wire logic [6:0] ev_key = is_pedal ? {ped_down, 1'b0, 5'(ped_idx - PEDAL_LOW)}
                                     : {man_on, man_pitch};
  wire logic [7:0] ev_vel = is_pedal ? {1'b1, ped_down ? VEL_MAX : 7'h00}
                                     : {1'b0, man_on ? VEL_MAX - cnt : 7'h00};
  wire logic mem_we = init_we || (st_r == SC_UPD && !is_pedal);
  wire logic [5:0] mem_waddr = init_we ? init_r : man_pitch;
  wire logic [MEM_W-1:0] mem_wdata = init_we ? {KS_IDLE, 7'h00} : {ks_nxt, cnt_nxt};

  kvs_key_mem u_mem (
    .clk_i(CLK_I),
    .ce_i(CE_I),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(man_pitch),
    .rdata_o(mem_rdata)
  );

  // scan sequencer
  always_comb begin
    st_nxt = st_r;
    row_nxt = row_r;
    case (st_r)
      SC_INIT: if (init_r == 6'h3f) st_nxt = SC_WAIT;
      SC_WAIT: begin
        if (tick_pend_r) begin
          st_nxt = SC_SETTLE;
          row_nxt = 4'h0;
        end
      end
      SC_SETTLE: begin
        if (settle_r == 8'h00) begin
          st_nxt = row_r == ROW_JUMPER ? SC_WAIT : SC_RD;
        end
      end
      // a pending request holds the scan until the master fetches it
      SC_RD: if (!irq_r) st_nxt = SC_UPD;
      SC_UPD: begin
        st_nxt = SC_RD;
        if (key_r == KEY_LAST) begin
          st_nxt = SC_SETTLE;
          row_nxt = row_r + 4'h1;
        end
      end
      default: st_nxt = SC_WAIT;
    endcase
  end

  wire logic driving = st_nxt == SC_SETTLE || st_nxt == SC_RD || st_nxt == SC_UPD;
  wire logic [SLOTS-1:0] drv_nxt = driving ? ~(13'h0001 << row_nxt) : DRV_IDLE;
  wire logic irq_nxt = ev_set || (irq_r && !rd_vel);

  // pin synchronisers
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      con_s1_r <= '1;
      con_s2_r <= '1;
      ret_s1_r <= '1;
      ret_s2_r <= '1;
      rate_s1_r <= RATE_RST;
      rate_s2_r <= RATE_RST;
    end else if (CE_I) begin
      con_s1_r <= CONTACT_I;
      con_s2_r <= con_s1_r;
      ret_s1_r <= PEDAL_RETURN_LINE_I;
      ret_s2_r <= ret_s1_r;
      rate_s1_r <= RATE_SEL_I;
      rate_s2_r <= rate_s1_r;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_r <= SC_INIT;
      row_r <= 4'h0;
      key_r <= 3'h0;
      init_r <= 6'h00;
      settle_r <= 8'h00;
      drv_n_r <= DRV_IDLE;
    end else if (CE_I) begin
      st_r <= st_nxt;
      row_r <= row_nxt;
      drv_n_r <= drv_nxt;
      init_r <= init_r + 6'h01;
      if (st_r == SC_UPD) key_r <= key_r + 3'h1;
      // settling covers line delay plus the two synchroniser stages
      if (st_nxt == SC_SETTLE && st_r != SC_SETTLE) begin
        settle_r <= SETTLE_LOAD;
      end else if (settle_r != 8'h00) begin
        settle_r <= settle_r - 8'h01;
      end
    end
  end

  // poll timer; rate taken once, when the memory clear ends
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tmr_r <= 32'h0;
      tick_pend_r <= 1'b0;
      rate_r <= RATE_RST;
      rate_taken_r <= 1'b0;
    end else if (CE_I) begin
      if (st_r == SC_INIT && init_r == 6'h3f && !rate_taken_r) begin
        rate_r <= rate_s2_r;
        rate_taken_r <= 1'b1;
      end
      tmr_r <= tick ? period_w - 32'h1 : tmr_r - 32'h1;
      tick_pend_r <= (tick && rate_taken_r) || (tick_pend_r && st_r != SC_WAIT);
    end
  end

  // pedal state, jumpers, event bytes, port
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pedal_r <= 32'h0;
      OPTION_JUMPERS_O <= BYTE_RST;
      ev_key_r <= 7'h00;
      vel_r <= BYTE_RST;
      irq_r <= 1'b0;
      mask_r <= MASK_RST;
      BUS_RDATA_O <= BYTE_RST;
      FAST_INTERRUPT_REQUEST_N_O <= 1'b1;
      MATRIX_ADDR_N_O <= '1;
      PEDAL_SEL_N_O <= '1;
      JUMPER_SEL_N_O <= 1'b1;
    end else if (CE_I) begin
      if (st_r == SC_UPD && is_pedal) pedal_r[ped_idx] <= ped_down;
      if (st_r == SC_SETTLE && settle_r == 8'h00 && row_r == ROW_JUMPER) begin
        OPTION_JUMPERS_O <= ~ret_s2_r;
      end
      if (ev_set) begin
        ev_key_r <= ev_key;
        vel_r <= ev_vel;
      end
      irq_r <= irq_nxt;
      if (wr_mask) mask_r <= BUS_WDATA_I[MASK_BIT];
      if (rd_key) BUS_RDATA_O <= {irq_r, ev_key_r};
      else if (rd_vel) BUS_RDATA_O <= vel_r;
      FAST_INTERRUPT_REQUEST_N_O <= !(irq_nxt && !mask_r);
      MATRIX_ADDR_N_O <= drv_nxt[ROWS_MAN-1:0];
      PEDAL_SEL_N_O <= drv_nxt[ROWS_MAN+PED_SEL-1:ROWS_MAN];
      JUMPER_SEL_N_O <= drv_nxt[SLOTS-1];
    end
  end

  property p_irq_line;
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && ev_set && !mask_r && !wr_mask |=> !FAST_INTERRUPT_REQUEST_N_O;
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("request not raised");

  property p_mask;
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && mask_r && !wr_mask |=> FAST_INTERRUPT_REQUEST_N_O;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request reached line");

  property p_vel_clr;
    @(posedge CLK_I) disable iff (RESET_I)
    rd_vel && !ev_set |=> !irq_r ##1 (FAST_INTERRUPT_REQUEST_N_O || !CE_I);
  endproperty
  a_vel_clr: assert property (p_vel_clr) else $error("velocity read kept request");

  property p_key_rd;
    @(posedge CLK_I) disable iff (RESET_I)
    rd_key |=> BUS_RDATA_O[KB_IRQ] == $past(irq_r);
  endproperty
  a_key_rd: assert property (p_key_rd) else $error("key byte top bit wrong");

  property p_one_row;
    @(posedge CLK_I) disable iff (RESET_I)
    $onehot0(~drv_n_r) && (st_r != SC_RD || drv_n_r[row_r] == 1'b0);
  endproperty
  a_one_row: assert property (p_one_row) else $error("matrix drive not single");

  property p_vel_val;
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && ev_set && !is_pedal && man_on |=> vel_r == {1'b0, VEL_MAX - $past(cnt)};
  endproperty
  a_vel_val: assert property (p_vel_val) else $error("velocity not from count");

  property p_sat;
    @(posedge CLK_I) disable iff (RESET_I)
    st_r == SC_UPD && ks == KS_TIMING && cnt == VEL_MAX |-> cnt_nxt == VEL_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("velocity count wrapped");

  property p_rate;
    @(posedge CLK_I) disable iff (RESET_I)
    rate_taken_r |=> rate_taken_r && $stable(rate_r);
  endproperty
  a_rate: assert property (p_rate) else $error("rate changed after reset");

  property p_pitch;
    @(posedge CLK_I) disable iff (RESET_I)
    ev_set |-> (is_pedal ? ev_key[4:0] <= 5'h1d : ev_key[5:0] < KEY_COUNT);
  endproperty
  a_pitch: assert property (p_pitch) else $error("pitch out of range");
endmodule
`default_nettype wire

/* test/kvs_master_model.sv */
// master processor model: answers the fast interrupt over the two-byte port
`timescale 1ns/10ps
`default_nettype none
module kvs_master_model (
  // clock, interrupt and read data
  input wire logic clk_i,
  input wire logic irq_n_i,
  input wire logic [7:0] rdata_i,
  // bench controls
  input wire logic poll_i,
  input wire logic mask_go_i,
  input wire logic mask_i,
  // bus drives
  output logic cs_o,
  output logic addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  // fetched event
  output logic evt_o,
  output logic [7:0] key_o,
  output logic [7:0] vel_o
);
  import kvs_pkg::*;
  logic [7:0] k;
  logic [7:0] v;
  // idle address and data toggle so a stale value is never mistaken for a held one
  task automatic xfer(input logic a, input logic w, input logic [7:0] wd, output logic [7:0] d);
    @(posedge clk_i);
    cs_o <= 1'b1;
    addr_o <= a;
    rd_o <= !w;
    wr_o <= w;
    wdata_o <= wd;
    @(posedge clk_i);
    cs_o <= 1'b0;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    addr_o <= !a;
    wdata_o <= ~wd;
    @(posedge clk_i);
    d = rdata_i;
  endtask
  // one process drives the bus, so every output has a single driver
  initial begin
    cs_o = 1'b0;
    addr_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h5a;
    evt_o = 1'b0;
    key_o = 8'h00;
    vel_o = 8'h00;
    forever begin
      @(posedge clk_i);
      if (mask_go_i) begin
        xfer(ADDR_KEY, 1'b1, {7'h00, mask_i}, k);
      end else if (!irq_n_i || poll_i) begin
        xfer(ADDR_KEY, 1'b0, 8'h00, k);
        if (k[KB_IRQ]) begin
          xfer(ADDR_VEL, 1'b0, 8'h00, v);
          key_o <= k;
          vel_o <= v;
          evt_o <= 1'b1;
          @(posedge clk_i);
          evt_o <= 1'b0;
          @(posedge clk_i);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// testbench: keyboard, pedal and jumper model with event scoreboard
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import kvs_pkg::*;
  localparam int POLL = 600;
  logic clk, rst, ce, cs, addr, rd, wr, irq_n, jsel_n, poll, mask_go, mask, evt;
  logic [7:0] wdata, rdata, row_n, ret, jmp_o, jmp, key_b, vel_b;
  logic [15:0] contact;
  logic [3:0] sel_n;
  logic [1:0] rate;
  logic rest_c [64];
  logic work_c [64];
  int ped, cyc, bad_count, samples_checked;
  int qk[$], qlo[$], qhi[$];

  kvs_scanner #(.POLL_BASE_CYCLES(POLL)) u_dut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce),
    .BUS_CS_I(cs), .BUS_ADDR_I(addr), .BUS_RD_I(rd), .BUS_WR_I(wr), .BUS_WDATA_I(wdata),
    .BUS_RDATA_O(rdata), .FAST_INTERRUPT_REQUEST_N_O(irq_n), .MATRIX_ADDR_N_O(row_n),
    .CONTACT_I(contact), .PEDAL_SEL_N_O(sel_n), .JUMPER_SEL_N_O(jsel_n),
    .PEDAL_RETURN_LINE_I(ret), .OPTION_JUMPERS_O(jmp_o), .RATE_SEL_I(rate));
  kvs_master_model u_master (.clk_i(clk), .irq_n_i(irq_n), .rdata_i(rdata), .poll_i(poll),
    .mask_go_i(mask_go), .mask_i(mask), .cs_o(cs), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .wdata_o(wdata), .evt_o(evt), .key_o(key_b), .vel_o(vel_b));

  // undriven rows and returns float high through the pull-ups
  always_comb begin
    contact = 16'hffff;
    for (int r = 0; r < 8; r++)
      if (!row_n[r])
        for (int k = 0; k < 8; k++) begin
          contact[2*k] = !rest_c[r*8+k];
          contact[2*k+1] = !work_c[r*8+k];
        end
  end
  always_comb begin
    ret = jsel_n ? 8'hff : ~jmp;
    for (int s = 0; s < 4; s++)
      if (!sel_n[s] && ped >= 0 && (ped + 2) / 8 == s) ret[(ped + 2) % 8] = 1'b0;
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(string n, int lo, int hi, logic [7:0] g);
    samples_checked++;
    if ($isunknown(g) || g < lo || g > hi) begin
      bad_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  // behavioural keyboard: change contacts, queue the event the master should fetch
  task automatic ev(bit pedal, int i, bit on, int lo, int hi);
    @(posedge clk);
    if (pedal) begin
      ped <= on ? i : -1;
      qk.push_back({1'b1, on, 1'b0, 5'(i)});
    end else begin
      rest_c[i] <= !on;
      work_c[i] <= on;
      qk.push_back({1'b1, on, 6'(i)});
    end
    qlo.push_back(lo);
    qhi.push_back(hi);
  endtask
  task automatic wait_done();
    for (int n = 0; n < 4000 && qk.size() > 0; n++) @(posedge clk);
    if (qk.size() > 0) begin
      bad_count++;
      $display("wrong value event count expected 0 seen %0d", qk.size());
      tally_and_finish();
    end
  endtask
  task automatic set_mask(logic m);
    @(posedge clk);
    mask <= m;
    mask_go <= 1'b1;
    // held past a whole key-byte poll, so a busy master still sees it
    repeat (6) @(posedge clk);
    mask_go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      bad_count++;
      tally_and_finish();
    end
    if (evt) begin
      if (qk.size() == 0) begin
        bad_count++;
        $display("wrong value spare event expected none seen %h", key_b);
      end else begin
        chk("key byte", 8'(qk.pop_front()), key_b);
        chk_rng("velocity", qlo.pop_front(), qhi.pop_front(), vel_b);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    int keys[3];
    int s;
    logic [7:0] rows;
    void'($urandom(52));
    rst = 1'b1;
    ce = 1'b1;
    rate = 2'h0;
    poll = 1'b0;
    mask_go = 1'b0;
    mask = 1'b0;
    ped = -1;
    cyc = 0;
    bad_count = 0;
    samples_checked = 0;
    jmp = 8'($urandom);
    foreach (rest_c[i]) rest_c[i] = 1'b1;
    foreach (work_c[i]) work_c[i] = 1'b0;
    repeat (2) @(posedge clk);
    chk("irq line", 8'h01, {7'h00, irq_n});
    chk("read data", BYTE_RST, rdata);
    rst <= 1'b0;
    repeat (200) @(posedge clk);
    rate <= 2'(1 + $urandom % 3);
    repeat (1300) @(posedge clk);
    chk("jumpers", jmp, jmp_o);
    keys = '{0, 60, 1 + $urandom % 59};
    foreach (keys[j]) begin
      ev(1'b0, keys[j], 1'b1, 127, 127);
      wait_done();
      ev(1'b0, keys[j], 1'b0, 0, 0);
      wait_done();
    end
    // slow stroke: ten running poll periods, three more frozen by the clock enable
    s = $urandom % 61;
    @(posedge clk);
    rest_c[s] <= 1'b0;
    repeat (5 * POLL) @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    rows = row_n;
    repeat (3 * POLL - 2) @(posedge clk);
    chk("frozen rows", rows, row_n);
    ce <= 1'b1;
    repeat (5 * POLL) @(posedge clk);
    ev(1'b0, s, 1'b1, 127 - 11, 127 - 9);
    wait_done();
    ev(1'b0, s, 1'b0, 0, 0);
    wait_done();
    // masked request is only found by polling the key byte
    set_mask(1'b1);
    ev(1'b0, keys[2], 1'b1, 127, 127);
    repeat (1500) @(posedge clk);
    chk("masked irq line", 8'h01, {7'h00, irq_n});
    poll <= 1'b1;
    wait_done();
    poll <= 1'b0;
    set_mask(1'b0);
    ev(1'b0, keys[2], 1'b0, 0, 0);
    wait_done();
    foreach (keys[j]) begin
      s = (j == 0) ? 0 : (j == 1) ? 29 : $urandom % 30;
      ev(1'b1, s, 1'b1, 255, 255);
      wait_done();
      ev(1'b1, s, 1'b0, 128, 128);
      wait_done();
    end
    // second reset with rate code 1: polls twice as far apart
    rate <= 2'h1;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("reset read data", BYTE_RST, rdata);
    chk("reset jumpers", BYTE_RST, jmp_o);
    rst <= 1'b0;
    repeat (100) @(posedge clk);
    s = $urandom % 61;
    rest_c[s] <= 1'b0;
    repeat (8 * POLL) @(posedge clk);
    ev(1'b0, s, 1'b1, 127 - 5, 127 - 3);
    wait_done();
    ev(1'b0, s, 1'b0, 0, 0);
    wait_done();
    tally_and_finish();
  end
endmodule
`default_nettype wire
